/* File: design/jaie_defs.vh */
`ifndef JAIE_DEFS_VH
`define JAIE_DEFS_VH

// opcode patterns
`define JAIE_OP_JUMP 8'hef
`define JAIE_OP_JUMP2 4'hf
`define JAIE_OP_INC 6'h0a
`define JAIE_OP_ISZ 6'h0f
`define JAIE_OP_ISNZ 6'h12

// instruction field positions
`define JAIE_F_DEST 9
`define JAIE_F_BANK 8
`define JAIE_JUMP_HI_MSB 11

// addressing
`define JAIE_IDX_LIMIT 8'h5f
`define JAIE_ACC_SPLIT 8'h80
`define JAIE_ACC_HI_BANK 4'hf
`define JAIE_ACC_LO_BANK 4'h0

// program counter step per word
`define JAIE_PC_STEP 21'h000002

// apb register byte offsets
`define JAIE_REG_CTRL 8'h00
`define JAIE_REG_BANK 8'h04
`define JAIE_REG_WORK 8'h08
`define JAIE_REG_STAT 8'h0c
`define JAIE_REG_PC 8'h10

// control fields
`define JAIE_CTRL_RUN 0
`define JAIE_CTRL_EXT 1

// status fields
`define JAIE_ST_C 0
`define JAIE_ST_DIG 1
`define JAIE_ST_Z 2
`define JAIE_ST_OVF 3
`define JAIE_ST_N 4
`define JAIE_ST_FLUSH 5

// reset values
`define JAIE_RST_RUN 1'b0
`define JAIE_RST_EXT 1'b0
`define JAIE_RST_BANK 4'h0
`define JAIE_RST_WORK 8'h00
`define JAIE_RST_FLAGS 5'h00
`define JAIE_RST_PC 21'h000000

`endif

/* File: design/jaie_exec.v */
// Function
// RULE1: jump is two words: high byte 1110 1111 plus k7..0, then 1111 plus k19..8.
// RULE2: jump loads 20-bit literal into PC bits 20..1; flags unchanged.
// RULE3: jump takes two cycles; low literal in Q2, high literal and PC in Q4.
// RULE4: increment is one word: six fixed bits, destination bit, bank bit, address.
// RULE5: increment adds one and updates carry, digit carry, negative, overflow, zero.
// RULE6: destination bit 0 writes working register, 1 writes addressed register.
// RULE7: bank bit 0 uses access bank, 1 uses bank select register.
// RULE8: bank bit 0, extended set, address up to 5Fh uses indexed offset.
// RULE9: skip-on-zero stores like increment, no flags, discards next if zero.
// RULE10: skipping a two-word instruction inserts one more no-operation cycle.
// RULE11: increment is one cycle: decode, read, process, write across quarters.
// RULE12: skip-on-nonzero is the same but skips when result is not zero.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ns
`include "jaie_defs.vh"

module jaie_exec #(
  parameter PC_W = 21,
  parameter DADDR_W = 12
) (
  // clock and reset
  input wire clock_i,
  input wire reset_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // program memory fetch
  output wire [PC_W-1:0] prog_addr_o,
  output reg prog_rd_o,
  input wire [15:0] prog_data_i,
  // data register file
  output reg [DADDR_W-1:0] data_addr_o,
  output reg data_rd_o,
  output reg data_wr_o,
  output reg [7:0] data_wdata_o,
  input wire [7:0] data_rdata_i,
  input wire [DADDR_W-1:0] index_base_i
);

  localparam [3:0] Q1 = 4'b0001;
  localparam [3:0] Q2 = 4'b0010;
  localparam [3:0] Q3 = 4'b0100;
  localparam [3:0] Q4 = 4'b1000;

  localparam [3:0] OP_NONE = 4'b0000;
  localparam [3:0] OP_JUMP = 4'b0001;
  localparam [3:0] OP_INC = 4'b0010;
  localparam [3:0] OP_ISZ = 4'b0100;
  localparam [3:0] OP_ISNZ = 4'b1000;

  reg [3:0] q;
  reg [PC_W-1:0] pc;
  reg [15:0] fetch_word;
  reg [15:0] ir;
  reg [3:0] op;
  reg dest_f;
  reg [7:0] lit_lo;
  reg [7:0] operand;
  reg [7:0] result;
  reg skip_take;
  reg flush;
  reg flush_skip;
  reg [7:0] wreg;
  reg [4:0] flags;
  reg [3:0] bank_select_reg;
  reg run_en;
  reg ext_en;

  wire [7:0] inc_result;
  wire [4:0] inc_flags;
  wire [5:0] opc;
  wire [7:0] faddr;
  wire bank_bit;
  wire dec_jump;
  wire ir_two_word;
  wire op_any_inc;
  wire apb_acc;
  wire apb_done;
  reg [3:0] next_op;
  reg [DADDR_W-1:0] next_data_addr;
  reg [31:0] next_prdata;
  reg next_pslverr;

  jaie_incr u_incr (
    .operand_i(operand),
    .result_o(inc_result),
    .flags_o(inc_flags)
  );

  assign prog_addr_o = pc;
  assign opc = fetch_word[15:10];
  assign faddr = fetch_word[7:0];
  assign bank_bit = fetch_word[`JAIE_F_BANK];
  assign dec_jump = (fetch_word[15:8] == `JAIE_OP_JUMP); // [RULE1]
  assign ir_two_word = (ir[15:8] == `JAIE_OP_JUMP); // [RULE10]
  assign op_any_inc = |op[3:1];
  assign apb_acc = psel_i & penable_i;
  assign apb_done = apb_acc & pready_o;

  // decode of the word about to execute
  always @* begin
    next_op = OP_NONE;
    if (!flush) begin
      if (dec_jump) begin
        next_op = OP_JUMP; // [RULE1]
      end else if (opc == `JAIE_OP_INC) begin
        next_op = OP_INC; // [RULE4]
      end else if (opc == `JAIE_OP_ISZ) begin
        next_op = OP_ISZ; // [RULE9]
      end else if (opc == `JAIE_OP_ISNZ) begin
        next_op = OP_ISNZ; // [RULE12]
      end
    end
  end

  // operand address: indexed, access bank or selected bank
  always @* begin
    if (bank_bit) begin
      next_data_addr = {bank_select_reg, faddr}; // [RULE7]
    end else if (ext_en && (faddr <= `JAIE_IDX_LIMIT)) begin
      next_data_addr = index_base_i + {4'h0, faddr}; // [RULE8]
    end else if (faddr < `JAIE_ACC_SPLIT) begin
      next_data_addr = {`JAIE_ACC_LO_BANK, faddr}; // [RULE7]
    end else begin
      next_data_addr = {`JAIE_ACC_HI_BANK, faddr}; // [RULE7]
    end
  end

  // apb read mux
  always @* begin
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    if (paddr_i == `JAIE_REG_CTRL) begin
      next_prdata[`JAIE_CTRL_RUN] = run_en;
      next_prdata[`JAIE_CTRL_EXT] = ext_en;
    end else if (paddr_i == `JAIE_REG_BANK) begin
      next_prdata[3:0] = bank_select_reg;
    end else if (paddr_i == `JAIE_REG_WORK) begin
      next_prdata[7:0] = wreg;
    end else if (paddr_i == `JAIE_REG_STAT) begin
      next_prdata[4:0] = flags;
      next_prdata[`JAIE_ST_FLUSH] = flush;
    end else if (paddr_i == `JAIE_REG_PC) begin
      next_prdata[PC_W-1:0] = pc;
    end else begin
      next_pslverr = 1'b1;
    end
  end

  // apb slave: one wait state, answer registered
  always @(posedge clock_i) begin
    if (reset_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= apb_acc & ~pready_o;
      if (apb_acc && !pready_o) begin
        prdata_o <= pwrite_i ? 32'h00000000 : next_prdata;
        pslverr_o <= next_pslverr;
      end else begin
        prdata_o <= 32'h00000000;
        pslverr_o <= 1'b0;
      end
    end
  end

  // software control registers
  always @(posedge clock_i) begin
    if (reset_i) begin
      run_en <= `JAIE_RST_RUN;
      ext_en <= `JAIE_RST_EXT;
      bank_select_reg <= `JAIE_RST_BANK;
    end else if (apb_done && pwrite_i) begin
      if (paddr_i == `JAIE_REG_CTRL) begin
        run_en <= pwdata_i[`JAIE_CTRL_RUN];
        ext_en <= pwdata_i[`JAIE_CTRL_EXT];
      end else if (paddr_i == `JAIE_REG_BANK) begin
        bank_select_reg <= pwdata_i[3:0];
      end
    end
  end

  // quarter sequencer; halts only at an instruction boundary
  always @(posedge clock_i) begin
    if (reset_i) begin
      q <= Q1;
    end else begin
      case (q)
        Q1: begin
          if (run_en) begin
            q <= Q2;
          end
        end
        Q2: begin
          q <= Q3;
        end
        Q3: begin
          q <= Q4;
        end
        Q4: begin
          q <= Q1;
        end
        default: begin
          q <= Q1;
        end
      endcase
    end
  end

  // execute datapath
  always @(posedge clock_i) begin
    if (reset_i) begin
      pc <= `JAIE_RST_PC;
      fetch_word <= 16'h0000;
      ir <= 16'h0000;
      op <= OP_NONE;
      dest_f <= 1'b0;
      lit_lo <= 8'h00;
      operand <= 8'h00;
      result <= 8'h00;
      skip_take <= 1'b0;
      flush <= 1'b1;
      flush_skip <= 1'b0;
      wreg <= `JAIE_RST_WORK;
      flags <= `JAIE_RST_FLAGS;
      prog_rd_o <= 1'b0;
      data_addr_o <= {DADDR_W{1'b0}};
      data_rd_o <= 1'b0;
      data_wr_o <= 1'b0;
      data_wdata_o <= 8'h00;
    end else begin
      if (apb_done && pwrite_i && (paddr_i == `JAIE_REG_WORK)) begin
        wreg <= pwdata_i[7:0];
      end
      case (q)
        Q1: begin
          if (run_en) begin
            // decode; a flushed word runs as no operation
            ir <= fetch_word;
            op <= next_op;
            skip_take <= 1'b0;
            dest_f <= fetch_word[`JAIE_F_DEST];
            data_addr_o <= next_data_addr;
            data_rd_o <= |next_op[3:1]; // [RULE11]
          end
        end
        Q2: begin
          data_rd_o <= 1'b0;
          if (op_any_inc) begin
            operand <= data_rdata_i; // [RULE11]
          end
          if (op == OP_JUMP) begin
            lit_lo <= ir[7:0]; // [RULE3]
          end
        end
        Q3: begin
          result <= inc_result;
          if (op == OP_INC) begin
            flags <= inc_flags; // [RULE5]
          end
          skip_take <= ((op == OP_ISZ) && inc_flags[`JAIE_ST_Z]) || // [RULE9]
                       ((op == OP_ISNZ) && !inc_flags[`JAIE_ST_Z]); // [RULE12]
          if (op_any_inc && dest_f) begin
            data_wr_o <= 1'b1; // [RULE6]
            data_wdata_o <= inc_result;
          end
          prog_rd_o <= 1'b1;
        end
        Q4: begin
          data_wr_o <= 1'b0;
          prog_rd_o <= 1'b0;
          if (op_any_inc && !dest_f) begin
            wreg <= result; // [RULE6]
          end
          fetch_word <= prog_data_i;
          if (op == OP_JUMP) begin
            // second word holds target bits 19..8
            pc <= {prog_data_i[`JAIE_JUMP_HI_MSB:0], lit_lo, 1'b0}; // [RULE2] [RULE3]
          end else begin
            pc <= pc + `JAIE_PC_STEP;
          end
          // after a jump, a taken skip or a skipped two-word instruction, the next cycle executes no operation
          flush <= (op == OP_JUMP) || skip_take || (flush_skip && ir_two_word); // [RULE3] [RULE10]
          flush_skip <= skip_take; // [RULE9]
        end
        default: begin
          data_rd_o <= 1'b0;
        end
      endcase
    end
  end

endmodule

/* File: design/jaie_incr.v */
`timescale 1ns/1ns
`include "jaie_defs.vh"

module jaie_incr (
  // operand
  input wire [7:0] operand_i,
  // result and flags
  output wire [7:0] result_o,
  output wire [4:0] flags_o
);

  wire [8:0] sum;

  assign sum = {1'b0, operand_i} + 9'h001;
  assign result_o = sum[7:0];
  assign flags_o[`JAIE_ST_C] = sum[8];
  assign flags_o[`JAIE_ST_DIG] = (operand_i[3:0] == 4'hf);
  assign flags_o[`JAIE_ST_Z] = (sum[7:0] == 8'h00);
  // signed overflow only from +127 to -128
  assign flags_o[`JAIE_ST_OVF] = (operand_i == 8'h7f);
  assign flags_o[`JAIE_ST_N] = sum[7];

endmodule

/* File: tb/jaie_exec_monitor.sv */
`timescale 1ns/1ns
module jaie_exec_monitor #(
  parameter PC_W = 21,
  parameter DADDR_W = 12
) (
  // clock and reset
  input wire clock_i,
  input wire reset_i,
  // apb
  input wire psel_i,
  input wire penable_i,
  input wire pready_o,
  // fetch and data file
  input wire [PC_W-1:0] prog_addr_o,
  input wire prog_rd_o,
  input wire [DADDR_W-1:0] data_addr_o,
  input wire data_rd_o,
  input wire data_wr_o,
  input wire [7:0] data_wdata_o,
  input wire [7:0] data_rdata_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence s_read;
    data_rd_o ##1 !data_rd_o;
  endsequence
  sequence s_fetch;
    prog_rd_o ##1 !prog_rd_o [*3];
  endsequence
  a_read_pulse: assert property (data_rd_o |-> s_read)
    else $error("read strobe too long");
  a_write_slot: assert property (data_wr_o |-> $past(data_rd_o, 2))
    else $error("write not in fourth quarter");
  a_write_value: assert property (data_wr_o |->
    data_wdata_o == $past(data_rdata_i, 2) + 8'h01)
    else $error("write data not operand plus one");
  a_addr_hold: assert property (data_rd_o |=> $stable(data_addr_o) [*2])
    else $error("data address moved");
  a_fetch_gap: assert property (prog_rd_o |-> s_fetch)
    else $error("fetch more than once per cycle");
  a_pc_moves: assert property ($changed(prog_addr_o) |-> $past(prog_rd_o))
    else $error("pc changed outside fourth quarter");
  a_pc_even: assert property (prog_addr_o[0] == 1'b0)
    else $error("pc bit zero set");
  a_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("apb wait state wrong");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
endmodule
bind jaie_exec jaie_exec_monitor #(.PC_W(PC_W), .DADDR_W(DADDR_W)) mon (.clock_i, .reset_i,
  .psel_i, .penable_i, .pready_o, .prog_addr_o, .prog_rd_o, .data_addr_o, .data_rd_o,
  .data_wr_o, .data_wdata_o, .data_rdata_i);

/* File: tb/jaie_mem_model.sv */
`timescale 1ns/1ns
module jaie_mem_model (
  // inputs from the core
  input wire clock_i,
  input wire [20:0] prog_addr_i,
  input wire prog_rd_i,
  input wire [11:0] data_addr_i,
  input wire data_rd_i,
  input wire data_wr_i,
  input wire [7:0] data_wdata_i,
  // answers
  output wire [15:0] prog_data_o,
  output wire [7:0] data_rdata_o
);
  logic [15:0] pmem [0:255];
  logic [7:0] dmem [0:4095];
  // idle lines show inverted contents so a mistimed sample cannot pass by luck
  assign prog_data_o = prog_rd_i ? pmem[prog_addr_i[8:1]] : ~pmem[prog_addr_i[8:1]];
  assign data_rdata_o = data_rd_i ? dmem[data_addr_i] : ~dmem[data_addr_i];
  always @(posedge clock_i) begin
    if (data_wr_i) begin
      dmem[data_addr_i] <= data_wdata_i;
    end
  end
endmodule

/* File: tb/test_jump_and_increment_exec.sv */
`timescale 1ns/1ns
`include "jaie_defs.vh"
module test_jump_and_increment_exec;
  logic clock_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, se;
  logic prog_rd_o, data_rd_o, data_wr_o;
  logic [7:0] paddr_i, data_wdata_o, data_rdata_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [20:0] prog_addr_o;
  logic [15:0] prog_data_i;
  logic [11:0] data_addr_o;
  logic [15:0] prog [9];
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  jaie_exec uut (.clock_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .prog_addr_o, .prog_rd_o, .prog_data_i, .data_addr_o,
    .data_rd_o, .data_wr_o, .data_wdata_o, .data_rdata_i, .index_base_i(12'h300));
  jaie_mem_model mem (.clock_i, .prog_addr_i(prog_addr_o), .prog_rd_i(prog_rd_o),
    .data_addr_i(data_addr_o), .data_rd_i(data_rd_o), .data_wr_i(data_wr_o),
    .data_wdata_i(data_wdata_o), .prog_data_o(prog_data_i), .data_rdata_o(data_rdata_i));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task end_sim;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      end_sim;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= addr;
    pwdata_i <= wd;
    @(posedge clock_i);
    penable_i <= 1'b1;
    @(posedge clock_i);
    while (pready_o !== 1'b1) @(posedge clock_i);
    rd = prdata_o;
    se = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // idle cycle keeps each strobe to one assignment per time step
    @(posedge clock_i);
  endtask
  task rchk(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(rd, exp);
  endtask
  task dchk(input logic [11:0] addr, input logic [7:0] exp);
    check({24'h0, mem.dmem[addr]}, {24'h0, exp});
  endtask
  initial begin
    reset_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    prog = '{16'h2a60, 16'h297f, 16'h3e70, 16'h2a71, 16'h4a90, 16'hef40, 16'hf000, 16'hef20,
      16'hf000};
    for (int i = 0; i < 256; i++) mem.pmem[i] = (i < 9) ? prog[i] : 16'h0000;
    for (int i = 0; i < 4096; i++) mem.dmem[i] = 8'h00;
    mem.pmem[32] = 16'h2a05;
    mem.pmem[64] = 16'h2a66;
    mem.dmem[12'h060] = 8'hff;
    mem.dmem[12'h27f] = 8'h7f;
    mem.dmem[12'h070] = 8'hff;
    mem.dmem[12'h071] = 8'h05;
    mem.dmem[12'hf90] = 8'h01;
    mem.dmem[12'h305] = 8'hff;
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    rchk(`JAIE_REG_WORK, 32'h0);
    rchk(`JAIE_REG_STAT, 32'h20);
    rchk(`JAIE_REG_PC, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    check(se, 32'h1);
    apb(1'b1, `JAIE_REG_BANK, 32'h2);
    rchk(`JAIE_REG_BANK, 32'h2);
    apb(1'b1, `JAIE_REG_CTRL, 32'h3);
    // program ends when the indexed increment after the jump lands
    while (mem.dmem[12'h305] !== 8'h00) @(posedge clock_i);
    repeat (8) @(posedge clock_i);
    apb(1'b1, `JAIE_REG_CTRL, 32'h2);
    dchk(12'h060, 8'h00);
    dchk(12'h27f, 8'h7f);
    rchk(`JAIE_REG_WORK, 32'h80);
    dchk(12'h070, 8'h00);
    dchk(12'h071, 8'h05);
    dchk(12'hf90, 8'h02);
    dchk(12'h066, 8'h00);
    dchk(12'h305, 8'h00);
    rchk(`JAIE_REG_STAT, 32'h07);
    rchk(`JAIE_REG_CTRL, 32'h2);
    // second reset with the core halted, then a lone increment with the extended set off
    reset_i <= 1'b1;
    for (int i = 1; i < 9; i++) mem.pmem[i] = 16'h0000;
    mem.pmem[0] = 16'h2840;
    mem.dmem[12'h040] = 8'h7f;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    rchk(`JAIE_REG_WORK, 32'h0);
    rchk(`JAIE_REG_BANK, 32'h0);
    rchk(`JAIE_REG_STAT, 32'h20);
    apb(1'b1, `JAIE_REG_CTRL, 32'h1);
    repeat (16) @(posedge clock_i);
    apb(1'b1, `JAIE_REG_CTRL, 32'h0);
    rchk(`JAIE_REG_WORK, 32'h80);
    rchk(`JAIE_REG_STAT, 32'h1a);
    dchk(12'h040, 8'h7f);
    dchk(12'h340, 8'h00);
    end_sim;
  end
endmodule
